/* include/frb_pkg.sv */
package frb_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 10000000;
	localparam int BTN_MS = 30;
	localparam int BTN_CYC = (CLK_HZ / 1000) * BTN_MS;
	// wait times in tenths of a second, range 0.0 to 10.0 s
	localparam int WAIT_W = 7;
	localparam int WAIT_MAX = 100;
	localparam int TENTH_CYC = CLK_HZ / 10;
	localparam logic [6:0] WAIT0_DEF = 7'h1e; // 3.0 s
	localparam logic [6:0] WAIT1_DEF = 7'h02; // 0.2 s
	localparam logic [6:0] WAIT2_DEF = 7'h01; // 0.1 s
	localparam logic [6:0] WAIT3_DEF = 7'h1e; // 3.0 s
	localparam logic [6:0] WAIT4_DEF = 7'h1e; // 3.0 s
	// ----------------------------------------------------------------
	// registers (wishbone, word aligned byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_WAIT01 = 8'h04;
	localparam logic [7:0] REG_WAIT234 = 8'h08;
	localparam logic [7:0] REG_LIMITS = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [3:0] SPEED_SRC_EMF = 4'h3;
	localparam logic [15:0] IFMIN_DEF = 16'h0100;
	localparam logic [15:0] FACTOR_DEF = 16'h00e6; // factor, 8.8 fixed point
	localparam logic [15:0] NMIN_DEF = 16'h0040;
	localparam int FACT_FRAC = 8;
	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE, ST_ARM_ZERO, ST_FIELD_LOW, ST_WAIT_OPEN, ST_WAIT_CLOSE,
		ST_WAIT_FIRE, ST_FIELD_RISE, ST_WAIT_ARM, ST_DECEL, ST_BRK_ZERO,
		ST_LOCKED, ST_DONE
	} frb_state_t;
endpackage

/* hdl/frb_timer.sv */
`timescale 1ns/10ps
// tenth-second countdown timer; done pulses once the loaded wait has run out
module frb_timer #(
	parameter int TICK_CYC = frb_pkg::TENTH_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic load_i,
	input wire logic [frb_pkg::WAIT_W-1:0] tenths_i,
	output logic done_o
);
	logic [31:0] tick;
	logic [frb_pkg::WAIT_W-1:0] left;
	logic run;
	wire tick_end = (tick == 32'(TICK_CYC - 1));

	// ----------------------------------------------------------------
	// counting
	// ----------------------------------------------------------------
	// zero wait pulses done two cycles after the load cycle
	always_ff @(posedge clk_i) begin
		if (rst_i || load_i) begin
			tick <= '0;
			left <= rst_i ? '0 : tenths_i;
			run <= !rst_i;
			done_o <= 1'b0;
		end else if (run) begin
			done_o <= 1'b0;
			if (left == '0) begin
				run <= 1'b0;
				done_o <= 1'b1;
			end else if (tick_end) begin
				tick <= '0;
				left <= left - {{(frb_pkg::WAIT_W-1){1'b0}}, 1'b1};
			end else begin
				tick <= tick + 32'h1;
			end
		end else begin
			done_o <= 1'b0;
		end
	end
endmodule // frb_timer

/* hdl/frb_sequencer.sv */
`timescale 1ns/10ps
module frb_sequencer #(
	parameter int BTN_CYC = frb_pkg::BTN_CYC,
	parameter int TICK_CYC = frb_pkg::TENTH_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// drive pins (asynchronous)
	input wire logic brake_request_i,
	input wire logic direction_select_i,
	input wire logic line_closed_i,
	input wire logic arm_current_zero_i,
	input wire logic stop_cmd_i,
	input wire logic switch_on_i,
	// measurements from the same clock
	input wire logic signed [15:0] speed_raw_i,
	input wire logic [15:0] field_current_actual_i,
	input wire logic [15:0] field_current_setpoint_i,
	// outputs
	output logic [1:0] field_contactor_outputs_o,
	output logic arm_pulse_enable_o,
	output logic field_pulse_enable_o,
	output logic zero_setpoint_o,
	output logic speed_invert_o,
	output logic signed [15:0] speed_actual_o,
	output logic locked_o
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	localparam int NSYNC = 6;
	logic [NSYNC-1:0] sync_a;
	logic [NSYNC-1:0] sync_b;
	wire [NSYNC-1:0] pins = {switch_on_i, stop_cmd_i, arm_current_zero_i,
		line_closed_i, direction_select_i, brake_request_i};
	// two flops per pin, only sync_b is read by logic
	always_ff @(posedge clk_i) begin
		sync_a <= rst_i ? '0 : pins;
		sync_b <= rst_i ? '0 : sync_a;
	end
	wire req_s = sync_b[0];
	wire dir_s = sync_b[1];
	wire line_s = sync_b[2];
	wire izero_s = sync_b[3];
	wire stop_s = sync_b[4];
	wire swon_s = sync_b[5];

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic enable;
	logic [3:0] speed_value_source;
	logic [6:0] wt0, wt1, wt2, wt3, wt4;
	logic [15:0] field_current_minimum;
	logic [15:0] field_current_ready_factor;
	logic [15:0] minimum_speed_threshold;
	frb_pkg::frb_state_t state, next_state;
	logic field_neg;
	logic ret_mode;
	logic stop_seen;

	wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wr = wb_req && wb_we_i && (wb_sel_i == 4'hf);
	wire sel_ctrl = (wb_adr_i == frb_pkg::REG_CTRL);
	wire sel_w01 = (wb_adr_i == frb_pkg::REG_WAIT01);
	wire sel_w234 = (wb_adr_i == frb_pkg::REG_WAIT234);
	wire sel_lim = (wb_adr_i == frb_pkg::REG_LIMITS);
	wire sel_stat = (wb_adr_i == frb_pkg::REG_STATUS);
	wire [31:0] rd_data = sel_ctrl ? {11'h000, minimum_speed_threshold, speed_value_source,
			enable} :
		sel_w01 ? {18'h00000, wt1, wt0} :
		sel_w234 ? {11'h000, wt4, wt3, wt2} :
		sel_lim ? {field_current_ready_factor, field_current_minimum} :
		sel_stat ? {25'h0000000, ret_mode, field_neg, locked_o, state} : 32'h0;

	// single-cycle ack; unmapped reads give zero, writes only with all lanes
	always_ff @(posedge clk_i) begin
		wb_ack_o <= !rst_i && wb_req;
		wb_dat_o <= rst_i ? 32'h0 : rd_data;
	end

	// software-written settings
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enable <= 1'b1;
			speed_value_source <= '0;
			minimum_speed_threshold <= frb_pkg::NMIN_DEF;
			wt0 <= frb_pkg::WAIT0_DEF;
			wt1 <= frb_pkg::WAIT1_DEF;
			wt2 <= frb_pkg::WAIT2_DEF;
			wt3 <= frb_pkg::WAIT3_DEF;
			wt4 <= frb_pkg::WAIT4_DEF;
			field_current_minimum <= frb_pkg::IFMIN_DEF;
			field_current_ready_factor <= frb_pkg::FACTOR_DEF;
		end else if (wr) begin
			if (sel_ctrl) begin
				enable <= wb_dat_i[0];
				speed_value_source <= wb_dat_i[4:1];
				minimum_speed_threshold <= wb_dat_i[20:5];
			end
			if (sel_w01) begin
				wt0 <= clip(wb_dat_i[6:0]);
				wt1 <= clip(wb_dat_i[13:7]);
			end
			if (sel_w234) begin
				wt2 <= clip(wb_dat_i[6:0]);
				wt3 <= clip(wb_dat_i[13:7]);
				wt4 <= clip(wb_dat_i[20:14]);
			end
			if (sel_lim) begin
				field_current_minimum <= wb_dat_i[15:0];
				field_current_ready_factor <= wb_dat_i[31:16];
			end
		end
	end

	// wait values above 10.0 s saturate
	function automatic logic [6:0] clip(input logic [6:0] v);
		clip = (v > 7'(frb_pkg::WAIT_MAX)) ? 7'(frb_pkg::WAIT_MAX) : v;
	endfunction

	// ----------------------------------------------------------------
	// button qualification
	// ----------------------------------------------------------------
	logic [31:0] btn_cnt;
	wire btn_held = (btn_cnt >= 32'(BTN_CYC));
	// count held-high cycles, line contactor closed throughout
	always_ff @(posedge clk_i) begin
		if (rst_i || !req_s || !line_s) begin
			btn_cnt <= '0;
		end else if (!btn_held) begin
			btn_cnt <= btn_cnt + 32'h1;
		end
	end

	// ----------------------------------------------------------------
	// speed and field arithmetic
	// ----------------------------------------------------------------
	wire invert_ok = (speed_value_source != frb_pkg::SPEED_SRC_EMF);
	wire signed [15:0] speed_int = speed_invert_o ? -speed_raw_i : speed_raw_i;
	wire braking = speed_int[15];
	wire [15:0] speed_mag = braking ? 16'(-speed_int) : speed_int;
	wire below_nmin = (speed_mag < minimum_speed_threshold);
	wire [31:0] field_ready_lvl = (32'(field_current_setpoint_i) *
		32'(field_current_ready_factor)) >> frb_pkg::FACT_FRAC;
	wire field_low = (field_current_actual_i < field_current_minimum);
	wire field_ready = (32'(field_current_actual_i) > field_ready_lvl);
	wire dir_differs = (dir_s != field_neg);

	// ----------------------------------------------------------------
	// timer
	// ----------------------------------------------------------------
	logic tmr_load;
	logic [6:0] tmr_val;
	logic tmr_done;
	frb_timer #(.TICK_CYC(TICK_CYC)) u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(tmr_load),
		.tenths_i(tmr_val),
		.done_o(tmr_done)
	);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	// next state and timer loads
	always_comb begin
		next_state = state;
		tmr_load = 1'b0;
		tmr_val = wt0;
		unique case (state)
			frb_pkg::ST_IDLE: begin
				if (enable && line_s && btn_held && braking) begin
					next_state = frb_pkg::ST_ARM_ZERO;
				end else if (enable && dir_differs) begin
					next_state = frb_pkg::ST_ARM_ZERO;
				end
			end
			frb_pkg::ST_ARM_ZERO: if (izero_s) next_state = frb_pkg::ST_FIELD_LOW;
			frb_pkg::ST_FIELD_LOW: begin
				if (field_low) begin
					next_state = frb_pkg::ST_WAIT_OPEN;
					tmr_load = 1'b1;
					tmr_val = wt0;
				end
			end
			frb_pkg::ST_WAIT_OPEN: begin
				if (tmr_done) begin
					next_state = frb_pkg::ST_WAIT_CLOSE;
					tmr_load = 1'b1;
					tmr_val = wt1;
				end
			end
			frb_pkg::ST_WAIT_CLOSE: begin
				if (tmr_done) begin
					next_state = frb_pkg::ST_WAIT_FIRE;
					tmr_load = 1'b1;
					tmr_val = wt2;
				end
			end
			frb_pkg::ST_WAIT_FIRE: if (tmr_done) next_state = frb_pkg::ST_FIELD_RISE;
			frb_pkg::ST_FIELD_RISE: begin
				if (field_ready) begin
					next_state = frb_pkg::ST_WAIT_ARM;
					tmr_load = 1'b1;
					tmr_val = ret_mode ? wt4 : wt3;
				end
			end
			frb_pkg::ST_WAIT_ARM: begin
				if (tmr_done) begin
					next_state = ret_mode ? frb_pkg::ST_DONE :
						(stop_seen ? frb_pkg::ST_DECEL : frb_pkg::ST_IDLE);
				end
			end
			frb_pkg::ST_DECEL: if (below_nmin) next_state = frb_pkg::ST_BRK_ZERO;
			frb_pkg::ST_BRK_ZERO: if (izero_s) next_state = frb_pkg::ST_LOCKED;
			frb_pkg::ST_LOCKED: begin
				if (!req_s) begin
					next_state = dir_differs ? frb_pkg::ST_ARM_ZERO :
						frb_pkg::ST_DONE;
				end
			end
			frb_pkg::ST_DONE: if (stop_seen && swon_s) next_state = frb_pkg::ST_IDLE;
			default: next_state = frb_pkg::ST_IDLE;
		endcase
	end

	// state, field direction, mode flags; stop_seen doubles as the brake marker
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= frb_pkg::ST_IDLE;
			field_neg <= 1'b0;
			ret_mode <= 1'b0;
			stop_seen <= 1'b0;
		end else begin
			state <= next_state;
			if (state == frb_pkg::ST_IDLE && next_state == frb_pkg::ST_ARM_ZERO) begin
				stop_seen <= line_s && btn_held && braking; // braking run or not
				ret_mode <= 1'b0;
			end
			if (state == frb_pkg::ST_LOCKED && next_state != frb_pkg::ST_LOCKED) begin
				ret_mode <= 1'b1;
				stop_seen <= 1'b0;
			end
			if (state == frb_pkg::ST_DONE) begin
				stop_seen <= stop_seen || stop_s;
			end
			if (state == frb_pkg::ST_WAIT_CLOSE && tmr_done) begin
				field_neg <= !field_neg;
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs, all registered
	// ----------------------------------------------------------------
	wire open_phase = (state == frb_pkg::ST_WAIT_CLOSE);
	wire hold_arm = (state != frb_pkg::ST_IDLE) && (state != frb_pkg::ST_DECEL);
	wire hold_field = (state == frb_pkg::ST_FIELD_LOW) || (state == frb_pkg::ST_WAIT_OPEN) ||
		open_phase || (state == frb_pkg::ST_WAIT_FIRE);
	wire [1:0] next_contactor = open_phase ? 2'h0 :
		(field_neg ? 2'h2 : 2'h1);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			field_contactor_outputs_o <= 2'h0;
			arm_pulse_enable_o <= 1'b0;
			field_pulse_enable_o <= 1'b0;
			zero_setpoint_o <= 1'b0;
			speed_invert_o <= 1'b0;
			speed_actual_o <= '0;
			locked_o <= 1'b0;
		end else begin
			field_contactor_outputs_o <= next_contactor;
			arm_pulse_enable_o <= !hold_arm;
			field_pulse_enable_o <= !hold_field;
			zero_setpoint_o <= (state == frb_pkg::ST_DECEL) ||
				(state == frb_pkg::ST_BRK_ZERO);
			if (state == frb_pkg::ST_WAIT_CLOSE && tmr_done && invert_ok) begin
				speed_invert_o <= !speed_invert_o;
			end
			speed_actual_o <= speed_int;
			locked_o <= (state == frb_pkg::ST_LOCKED) || (state == frb_pkg::ST_DONE);
		end
	end
endmodule // frb_sequencer

/* test/frb_sequencer_properties.sv */
`timescale 1ns/10ps
// ----
// port checker of the braking sequencer
// ----
module frb_seq_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic brake_request_i,
	input wire logic switch_on_i,
	input wire logic signed [15:0] speed_raw_i,
	input wire logic [1:0] field_contactor_outputs_o,
	input wire logic arm_pulse_enable_o,
	input wire logic field_pulse_enable_o,
	input wire logic speed_invert_o,
	input wire logic signed [15:0] speed_actual_o,
	input wire logic locked_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// pending bus request, request held in lockout, lockout without switch-on
	sequence s_bus_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_lock_held; (locked_o && brake_request_i) [*4]; endsequence
	sequence s_no_switch; (locked_o && !switch_on_i) [*4]; endsequence
	// inversion settled for two cycles and no reset in the window
	sequence s_inv_settled;
		(speed_invert_o == $past(speed_invert_o)) && (speed_invert_o == $past(speed_invert_o, 2))
			&& !$past(rst_i) && !$past(rst_i, 2);
	endsequence
	property p_ack_next; s_bus_req |=> wb_ack_o; endproperty
	a_ack_next: assert property (p_ack_next) else $error("bus ack not given in next cycle");
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("bus ack longer than one cycle");
	property p_never_both; field_contactor_outputs_o != 2'b11; endproperty
	a_never_both: assert property (p_never_both) else $error("both contactors closed");
	property p_open_off;
		field_contactor_outputs_o == 2'b00 |-> !arm_pulse_enable_o && !field_pulse_enable_o;
	endproperty
	a_open_off: assert property (p_open_off) else $error("firing while no contactor");
	property p_break_make;
		$rose(field_contactor_outputs_o[0]) || $rose(field_contactor_outputs_o[1])
			|-> $past(field_contactor_outputs_o) == 2'b00;
	endproperty
	a_break_make: assert property (p_break_make) else $error("close without open gap");
	property p_speed_track;
		s_inv_settled |-> speed_actual_o == (speed_invert_o ? -$past(speed_raw_i) : $past(speed_raw_i));
	endproperty
	a_speed_track: assert property (p_speed_track) else $error("speed value sign wrong");
	property p_locked_arm; locked_o |-> !arm_pulse_enable_o; endproperty
	a_locked_arm: assert property (p_locked_arm) else $error("armature fires in lockout");
	property p_lock_hold; s_lock_held |=> locked_o; endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("lockout left with request");
	property p_no_switch; s_no_switch |=> !arm_pulse_enable_o; endproperty
	a_no_switch: assert property (p_no_switch) else $error("armature enabled without switch-on");
endmodule // frb_seq_checker

bind frb_sequencer frb_seq_checker i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.brake_request_i, .switch_on_i, .speed_raw_i, .field_contactor_outputs_o, .arm_pulse_enable_o,
	.field_pulse_enable_o, .speed_invert_o, .speed_actual_o, .locked_o);

/* test/frb_drive_model.sv */
`timescale 1ns/10ps
// ----
// field circuit and armature converter behind the contactors
// ----
module frb_drive_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic slow_i,
	input wire logic [1:0] contactor_i,
	input wire logic arm_enable_i,
	input wire logic field_enable_i,
	output logic arm_current_zero_o,
	output logic [15:0] field_current_o
);
	logic [3:0] arm_decay;
	logic field_live;
	logic [15:0] step;
	// current builds only with field firing and exactly one contactor closed
	assign field_live = field_enable_i && (contactor_i == 2'b01 || contactor_i == 2'b10);
	assign step = slow_i ? 16'h0008 : 16'h0040;
	assign arm_current_zero_o = arm_decay >= (slow_i ? 4'hc : 4'h3);
	// armature current decays some cycles after pulse inhibit
	always_ff @(posedge clk_i) begin
		if (rst_i || arm_enable_i) begin
			arm_decay <= 4'h0;
		end else if (arm_decay != 4'hf) begin
			arm_decay <= arm_decay + 4'h1;
		end
	end
	// field current ramps to full value or decays to zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			field_current_o <= 16'h0000;
		end else if (field_live && field_current_o < 16'h0400) begin
			field_current_o <= field_current_o + step;
		end else if (!field_live) begin
			field_current_o <= (field_current_o > step) ? field_current_o - step : 16'h0000;
		end
	end
endmodule // frb_drive_model

/* test/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	logic clk_i = 1'b0, rst_i = 1'b1, slow = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [3:0] sel_req = 4'hf;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic brake_request_i = 1'b0, direction_select_i = 1'b0, line_closed_i = 1'b1;
	logic stop_cmd_i = 1'b0, switch_on_i = 1'b0, arm_current_zero_i;
	logic signed [15:0] speed_raw_i = 16'sh0000, speed_actual_o;
	logic [15:0] field_current_actual_i, field_current_setpoint_i = 16'h0400;
	logic [1:0] field_contactor_outputs_o;
	logic arm_pulse_enable_o, field_pulse_enable_o, zero_setpoint_o, speed_invert_o, locked_o;
	int error_cnt = 0, checks_done = 0, cyc_cnt = 0;
	// ----
	// clock, design and drive model
	// ----
	always #50 clk_i = ~clk_i;
	frb_sequencer #(.BTN_CYC(30), .TICK_CYC(10)) i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .brake_request_i,
		.direction_select_i, .line_closed_i, .arm_current_zero_i, .stop_cmd_i, .switch_on_i,
		.speed_raw_i, .field_current_actual_i, .field_current_setpoint_i,
		.field_contactor_outputs_o, .arm_pulse_enable_o, .field_pulse_enable_o,
		.zero_setpoint_o, .speed_invert_o, .speed_actual_o, .locked_o);
	frb_drive_model i_model (.clk_i, .rst_i, .slow_i(slow),
		.contactor_i(field_contactor_outputs_o), .arm_enable_i(arm_pulse_enable_o),
		.field_enable_i(field_pulse_enable_o), .arm_current_zero_o(arm_current_zero_i),
		.field_current_o(field_current_actual_i));
	// ----
	// shared tasks
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	// one classic wishbone cycle, held until ack
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= sel_req;
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wait_ctr(input logic [1:0] v);
		while (field_contactor_outputs_o !== v) @(posedge clk_i);
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ----
	// scenarios
	// ----
	// defaults, partial-select write, unmapped read, contactor after reset
	task automatic t_regs;
		wb(1'b0, frb_pkg::REG_WAIT01, 32'h0);
		chk(rd, {18'h0, frb_pkg::WAIT1_DEF, frb_pkg::WAIT0_DEF});
		wb(1'b0, frb_pkg::REG_WAIT234, 32'h0);
		chk(rd, {11'h0, frb_pkg::WAIT4_DEF, frb_pkg::WAIT3_DEF, frb_pkg::WAIT2_DEF});
		wb(1'b0, frb_pkg::REG_LIMITS, 32'h0);
		chk(rd, {frb_pkg::FACTOR_DEF, frb_pkg::IFMIN_DEF});
		sel_req = 4'h3;
		wb(1'b1, frb_pkg::REG_WAIT01, 32'h0);
		sel_req = 4'hf;
		wb(1'b1, 8'h24, 32'hffffffff);
		wb(1'b0, 8'h24, 32'h0);
		chk(rd, 32'h0);
		wb(1'b0, frb_pkg::REG_WAIT01, 32'h0);
		chk(rd, {18'h0, frb_pkg::WAIT1_DEF, frb_pkg::WAIT0_DEF});
		chk({30'h0, field_contactor_outputs_o}, 32'h1);
	endtask
	// short press, then a long press while not braking
	task automatic t_refuse;
		speed_raw_i <= -16'sd500;
		brake_request_i <= 1'b1;
		cycles(20);
		brake_request_i <= 1'b0;
		speed_raw_i <= 16'sd500;
		cycles(5);
		brake_request_i <= 1'b1;
		cycles(60);
		brake_request_i <= 1'b0;
		wb(1'b0, frb_pkg::REG_STATUS, 32'h0);
		chk({28'h0, rd[3:0]}, 32'h0);
	endtask
	// full braking run, lockout, return changeover and restart
	task automatic t_brake;
		int n;
		speed_raw_i <= -16'sd500;
		brake_request_i <= 1'b1;
		wait_ctr(2'b00);
		chk({31'h0, field_pulse_enable_o}, 32'h0);
		n = 0;
		while (field_contactor_outputs_o !== 2'b10) begin
			@(posedge clk_i);
			n++;
		end
		chk({31'h0, n >= 20 && n <= 23}, 32'h1);
		cycles(3);
		chk({16'h0, speed_actual_o}, 32'h1f4);
		while (zero_setpoint_o !== 1'b1) @(posedge clk_i);
		chk({31'h0, arm_pulse_enable_o}, 32'h1);
		chk({31'h0, field_pulse_enable_o}, 32'h1);
		speed_raw_i <= 16'sd0;
		while (locked_o !== 1'b1) @(posedge clk_i);
		cycles(50);
		wb(1'b0, frb_pkg::REG_STATUS, 32'h0);
		chk({27'h0, rd[4:0]}, 32'h1a);
		brake_request_i <= 1'b0;
		wait_ctr(2'b01);
		chk({31'h0, speed_invert_o}, 32'h0);
		do wb(1'b0, frb_pkg::REG_STATUS, 32'h0); while (rd[3:0] !== 4'hb);
		switch_on_i <= 1'b1;
		cycles(10);
		switch_on_i <= 1'b0;
		chk({31'h0, locked_o}, 32'h1);
		stop_cmd_i <= 1'b1;
		cycles(5);
		stop_cmd_i <= 1'b0;
		switch_on_i <= 1'b1;
		cycles(8);
		switch_on_i <= 1'b0;
		chk({30'h0, locked_o, arm_pulse_enable_o}, 32'h1);
	endtask
	// emf speed source, slow field, direction flip ignored mid reversal
	task automatic t_emf;
		wb(1'b1, frb_pkg::REG_CTRL, {11'h0, frb_pkg::NMIN_DEF, frb_pkg::SPEED_SRC_EMF, 1'b1});
		slow <= 1'b1;
		speed_raw_i <= 16'sd100;
		direction_select_i <= 1'b1;
		wait_ctr(2'b00);
		direction_select_i <= 1'b0;
		wait_ctr(2'b10);
		cycles(3);
		chk({15'h0, speed_invert_o, speed_actual_o}, 32'h64);
		wb(1'b0, frb_pkg::REG_STATUS, 32'h0);
		chk({31'h0, rd[5]}, 32'h1);
	endtask
	// hang guard
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 30000) begin
			error_cnt++;
			print_verdict;
		end
	end
	initial begin
		cycles(12);
		rst_i <= 1'b0;
		cycles(4);
		t_regs;
		t_refuse;
		t_brake;
		t_emf;
		print_verdict;
	end
endmodule // tb_top
